// ==== src/emb_params.svh ====
// offsets, field positions, reset values and sizes of the external bus interface
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
`define EMB_ADDR_W 8
`define EMB_OFS_CTRL 8'h00
`define EMB_OFS_WAIT 8'h04
`define EMB_OFS_STATUS 8'h08
`define EMB_OFS_WDATA 8'h0C
`define EMB_OFS_CMD 8'h10
`define EMB_OFS_RDATA 8'h14
`define EMB_CTRL_VIS 0
`define EMB_CTRL_PDN 1
`define EMB_CTRL_RESET 2'h1
`define EMB_WAIT_W 3
`define EMB_WAIT_RESET 3'h0
`define EMB_ST_BUSY 0
`define EMB_ST_ILLEGAL 1
`define EMB_ST_BOOT_EXT 2
`define EMB_ST_RD_VALID 3
`define EMB_CMD_ADDR_LSB 0
`define EMB_CMD_SPACE_LSB 16
`define EMB_CMD_GLOBAL 18
`define EMB_CMD_WRITE 19
`define EMB_SPACE_PROG 2'h0
`define EMB_SPACE_DATA 2'h1
`define EMB_SPACE_IO 2'h2
`define EMB_FIFO_DEPTH 4
`define EMB_RESP_OKAY 2'h0
`define EMB_RESP_SLVERR 2'h2
`endif

// ==== src/emb_pkg.sv ====
// types shared by the external bus interface
`default_nettype none
package emb_pkg;
  typedef struct packed {
    logic write;
    logic global_mem;
    logic [1:0] space;
    logic [15:0] addr;
    logic [15:0] data;
  } emb_req_t;
  typedef enum logic [1:0] {
    EMB_IDLE,
    EMB_ACCESS
  } emb_state_t;
endpackage
`default_nettype wire

// ==== src/emb_fifo.sv ====
// small request fifo with valid/ready on both sides
`default_nettype none
module emb_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // emb_fifo
`default_nettype wire

// ==== src/emb_top.sv ====
// external asynchronous memory and i/o bus interface with an axi4-lite register port
`include "emb_params.svh"
`default_nettype none

// How it works
// - space selects idle high; one goes low only while its space is accessed.
// - space selects float during reset, power down and emulation float.
// - write strobe low on every external write; data bus driven from its fall.
// - write and read strobes float while emulation float input is low.
// - read strobe low on every external read of any space.
// - direction high by default, low on writes; floats in power down or emulation.
// - bus cycle strobe goes low for every off-chip access.
// - bus cycle strobe floats in power down and emulation float.
// - global request on global data accesses; floats in reset, power down, emulation.
// - a slow device holds ready low; access extends one cycle at a time.
// - ready is sampled only with at least one programmed wait state.
// - boot source select sampled in reset chooses internal or external boot.
// - with the interface disabled every external access is an illegal address.
// - drive indicator low while the data bus drives in visibility mode.
// - visibility clock toggles every aclk cycle, so it runs at half the aclk rate.
// - visibility mode enabled from reset; data bus outputs while it is enabled.
module emb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`EMB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EMB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ready,
  input wire logic emulation_float_input_n,
  input wire logic external_interface_enable,
  input wire logic boot_source_select,
  output logic boot_from_external,
  output logic [15:0] ext_addr,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe,
  output logic io_space_select_n,
  output logic data_space_select_n,
  output logic program_space_select_n,
  output logic space_select_oe,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic strobe_oe,
  output logic direction_select,
  output logic direction_select_oe,
  output logic bus_cycle_strobe_n,
  output logic bus_cycle_strobe_oe,
  output logic global_data_request_n,
  output logic global_data_request_oe,
  output logic visibility_drive_indicator_n,
  output logic visibility_clock_out
);
  import emb_pkg::*;

  // pin synchronisers: ready, float, enable, boot select
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [15:0] data_meta;
  logic [15:0] data_sync;
  logic ready_s;
  logic float_n_s;
  logic ena_s;
  logic boot_s;

  assign pin_raw = {boot_source_select, external_interface_enable, emulation_float_input_n, ready};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        pin_meta[gi] <= pin_raw[gi];
        pin_sync[gi] <= pin_meta[gi];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    data_meta <= ext_data_in;
    data_sync <= data_meta;
  end

  assign ready_s = pin_sync[0];
  assign float_n_s = pin_sync[1];
  assign ena_s = pin_sync[2];
  assign boot_s = pin_sync[3];

  // software state
  logic [1:0] ctrl;
  logic [`EMB_WAIT_W-1:0] wait_state_control;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic illegal;
  logic rd_valid;
  logic visibility_mode;
  logic power_down;
  logic drive_ok;

  assign visibility_mode = ctrl[`EMB_CTRL_VIS];
  assign power_down = ctrl[`EMB_CTRL_PDN];
  assign drive_ok = float_n_s && !power_down;

  // boot select is caught while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_from_external <= boot_s;
    end
  end

  // axi4-lite write channel
  logic aw_got;
  logic w_got;
  logic [`EMB_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_bus_cycle_strobe;
  logic wr_do;
  logic wr_cmd;
  logic wr_ok;
  logic fifo_in_ready;
  emb_req_t cmd_req;

  assign wr_cmd = (aw_addr == `EMB_OFS_CMD);
  assign wr_do = aw_got && w_got && !s_axi_bvalid && (!wr_cmd || fifo_in_ready);
  assign wr_ok = (aw_addr == `EMB_OFS_CTRL) || (aw_addr == `EMB_OFS_WAIT) || (aw_addr == `EMB_OFS_STATUS)
    || (aw_addr == `EMB_OFS_WDATA) || wr_cmd;

  always_comb begin
    cmd_req.write = w_data[`EMB_CMD_WRITE];
    cmd_req.global_mem = w_data[`EMB_CMD_GLOBAL];
    cmd_req.space = w_data[`EMB_CMD_SPACE_LSB +: 2];
    cmd_req.addr = w_data[`EMB_CMD_ADDR_LSB +: 16];
    cmd_req.data = wdata_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_bus_cycle_strobe <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EMB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= {s_axi_awaddr[`EMB_ADDR_W-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_bus_cycle_strobe <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register writes; a command write pushes one request into the fifo
  logic set_illegal;
  logic set_rd_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `EMB_CTRL_RESET;
      wait_state_control <= `EMB_WAIT_RESET;
      wdata_reg <= 16'h0000;
    end else if (wr_do) begin
      if (aw_addr == `EMB_OFS_CTRL && w_bus_cycle_strobe[0]) begin
        ctrl <= w_data[1:0];
      end
      if (aw_addr == `EMB_OFS_WAIT && w_bus_cycle_strobe[0]) begin
        wait_state_control <= w_data[`EMB_WAIT_W-1:0];
      end
      if (aw_addr == `EMB_OFS_WDATA) begin
        if (w_bus_cycle_strobe[0]) begin
          wdata_reg[7:0] <= w_data[7:0];
        end
        if (w_bus_cycle_strobe[1]) begin
          wdata_reg[15:8] <= w_data[15:8];
        end
      end
    end
  end

  // sticky flags: write one to clear, a new event wins over the clear
  logic clr_hit;
  assign clr_hit = wr_do && aw_addr == `EMB_OFS_STATUS && w_bus_cycle_strobe[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      if (set_illegal) begin
        illegal <= 1'b1;
      end else if (clr_hit && w_data[`EMB_ST_ILLEGAL]) begin
        illegal <= 1'b0;
      end
      if (set_rd_valid) begin
        rd_valid <= 1'b1;
      end else if (clr_hit && w_data[`EMB_ST_RD_VALID]) begin
        rd_valid <= 1'b0;
      end
    end
  end

  // request fifo between the register port and the bus engine
  emb_req_t fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  emb_state_t state;

  emb_fifo #(
    .WIDTH($bits(emb_req_t)),
    .DEPTH(`EMB_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(cmd_req),
    .in_valid(wr_do && wr_cmd),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  assign fifo_pop = (state == EMB_IDLE) && fifo_out_valid;

  // axi4-lite read channel
  logic [31:0] rd_mux;
  logic rd_ok;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case ({s_axi_araddr[`EMB_ADDR_W-1:2], 2'b00})
      `EMB_OFS_CTRL: rd_mux[1:0] = ctrl;
      `EMB_OFS_WAIT: rd_mux[`EMB_WAIT_W-1:0] = wait_state_control;
      `EMB_OFS_STATUS: begin
        rd_mux[`EMB_ST_BUSY] = (state != EMB_IDLE) || fifo_out_valid;
        rd_mux[`EMB_ST_ILLEGAL] = illegal;
        rd_mux[`EMB_ST_BOOT_EXT] = boot_from_external;
        rd_mux[`EMB_ST_RD_VALID] = rd_valid;
      end
      `EMB_OFS_WDATA: rd_mux[15:0] = wdata_reg;
      `EMB_OFS_CMD: rd_mux = 32'h0000_0000;
      `EMB_OFS_RDATA: rd_mux[15:0] = rdata_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EMB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // external bus engine
  logic [`EMB_WAIT_W-1:0] wait_cnt;
  logic cur_write;
  logic access_done;

  assign access_done = (state == EMB_ACCESS) && (wait_cnt == '0)
    && ((wait_state_control == '0) || ready_s);
  assign set_illegal = fifo_pop && (!ena_s || fifo_out.space == 2'h3);
  assign set_rd_valid = access_done && !cur_write;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= EMB_IDLE;
      wait_cnt <= '0;
      cur_write <= 1'b0;
      rdata_reg <= 16'h0000;
      ext_addr <= 16'h0000;
      ext_data_out <= 16'h0000;
      io_space_select_n <= 1'b1;
      data_space_select_n <= 1'b1;
      program_space_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      direction_select <= 1'b1;
      bus_cycle_strobe_n <= 1'b1;
      global_data_request_n <= 1'b1;
    end else begin
      case (state)
        EMB_IDLE: begin
          if (fifo_pop && !set_illegal) begin
            state <= EMB_ACCESS;
            wait_cnt <= wait_state_control;
            cur_write <= fifo_out.write;
            ext_addr <= fifo_out.addr;
            ext_data_out <= fifo_out.data;
            program_space_select_n <= (fifo_out.space != `EMB_SPACE_PROG);
            data_space_select_n <= (fifo_out.space != `EMB_SPACE_DATA);
            io_space_select_n <= (fifo_out.space != `EMB_SPACE_IO);
            bus_cycle_strobe_n <= 1'b0;
            write_strobe_n <= !fifo_out.write;
            read_strobe_n <= fifo_out.write;
            direction_select <= !fifo_out.write;
            global_data_request_n <= !(fifo_out.global_mem && fifo_out.space == `EMB_SPACE_DATA);
          end
        end
        EMB_ACCESS: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else if (access_done) begin
            state <= EMB_IDLE;
            if (!cur_write) begin
              rdata_reg <= data_sync;
            end
            io_space_select_n <= 1'b1;
            data_space_select_n <= 1'b1;
            program_space_select_n <= 1'b1;
            bus_cycle_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            direction_select <= 1'b1;
            global_data_request_n <= 1'b1;
          end
        end
        default: state <= EMB_IDLE;
      endcase
    end
  end

  // output enables; selects and global request stay floating through reset
  logic next_write_drive;
  assign next_write_drive = (state == EMB_IDLE) ? (fifo_pop && !set_illegal && fifo_out.write)
    : (cur_write && !access_done);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      space_select_oe <= 1'b0;
      global_data_request_oe <= 1'b0;
      strobe_oe <= 1'b0;
      direction_select_oe <= 1'b0;
      bus_cycle_strobe_oe <= 1'b0;
      ext_data_oe <= 1'b0;
    end else begin
      space_select_oe <= drive_ok;
      global_data_request_oe <= drive_ok;
      strobe_oe <= float_n_s;
      direction_select_oe <= drive_ok;
      bus_cycle_strobe_oe <= drive_ok;
      ext_data_oe <= visibility_mode || next_write_drive;
    end
  end

  // visibility outputs; the indicator follows visibility_mode only, and the data bus always drives in visibility mode, so ext_data_oe is high while it is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      visibility_drive_indicator_n <= 1'b1;
      visibility_clock_out <= 1'b0;
    end else begin
      visibility_drive_indicator_n <= !visibility_mode;
      visibility_clock_out <= !visibility_clock_out;
    end
  end
endmodule // emb_top
`default_nettype wire

// ==== dv/emb_mem_model.sv ====
// behavioural external memory with ready stalls
`default_nettype none
module emb_mem_model (
  input wire logic aclk,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic io_space_select_n,
  input wire logic data_space_select_n,
  input wire logic program_space_select_n,
  input wire logic [3:0] stall,
  output logic [15:0] ext_data_in,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:2][0:15];
  logic [3:0] cnt = 4'h0;
  logic tog = 1'b0;
  int sp;
  assign sp = !program_space_select_n ? 0 : !data_space_select_n ? 1 : 2;
  // undriven bus shows a changing pattern
  assign ext_data_in = (!read_strobe_n && !ext_data_oe) ? mem[sp][ext_addr[3:0]] : {8{tog, ~tog}};
  always @(posedge aclk) begin
    tog <= ~tog;
    cnt <= (write_strobe_n && read_strobe_n) ? 4'h0 : cnt + 4'h1;
    ready <= (write_strobe_n && read_strobe_n) || (cnt + 4'h1 >= stall);
    if (!write_strobe_n) mem[sp][ext_addr[3:0]] <= ext_data_out;
  end
endmodule // emb_mem_model
`default_nettype wire

// ==== dv/emb_top_chk.sv ====
// concurrent checks on the external bus pins
`default_nettype none
module emb_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic emulation_float_input_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic io_space_select_n,
  input wire logic data_space_select_n,
  input wire logic program_space_select_n,
  input wire logic space_select_oe,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic strobe_oe,
  input wire logic direction_select,
  input wire logic bus_cycle_strobe_n,
  input wire logic bus_cycle_strobe_oe,
  input wire logic global_data_request_n,
  input wire logic ext_data_oe,
  input wire logic visibility_drive_indicator_n,
  input wire logic visibility_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sel_n;
  assign sel_n = {io_space_select_n, data_space_select_n, program_space_select_n};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_one_select: assert property ($countones(~sel_n) <= 1) else $error("two selects low");
  a_sel_idle: assert property (bus_cycle_strobe_n |-> sel_n == 3'h7) else $error("select outside cycle");
  a_strobe_cycle: assert property ((!write_strobe_n || !read_strobe_n) |->
    (!bus_cycle_strobe_n && (write_strobe_n ^ read_strobe_n))) else $error("bad strobes");
  a_dir_write: assert property (direction_select == (write_strobe_n || bus_cycle_strobe_n))
    else $error("direction wrong");
  a_cycle_steady: assert property ((!bus_cycle_strobe_n && $past(bus_cycle_strobe_n) == 1'b0) |->
    ($stable(sel_n) && $stable(direction_select))) else $error("cycle not steady");
  a_global_data: assert property (!global_data_request_n |-> !data_space_select_n) else $error("bad global");
  a_vis_clock: assert property (($past(aresetn) && $past(aresetn, 2)) |->
    visibility_clock_out != $past(visibility_clock_out)) else $error("clock stuck");
  a_float_all: assert property ((!emulation_float_input_n)[*5] |->
    (!space_select_oe && !strobe_oe && !bus_cycle_strobe_oe)) else $error("no float");
  a_drive_ind: assert property (!visibility_drive_indicator_n |-> ext_data_oe) else $error("indicator");
  a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("bvalid dropped");
  c_write: cover property (!write_strobe_n);
  c_read: cover property (!read_strobe_n);
  c_stall: cover property ((!bus_cycle_strobe_n)[*7]);
endmodule // emb_top_chk
bind emb_top emb_top_chk u_chk (.*);
`default_nettype wire

// ==== dv/tb_external_memory_bus_interface.sv ====
// randomised bench for the external bus interface
`include "emb_params.svh"
`default_nettype none
module tb_external_memory_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;
  import emb_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, vis = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, stall = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic emulation_float_input_n = 1, external_interface_enable = 1, boot_source_select = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ready, boot_from_external;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] ext_addr, ext_data_in, ext_data_out;
  logic ext_data_oe, io_space_select_n, data_space_select_n, program_space_select_n, space_select_oe;
  logic write_strobe_n, read_strobe_n, strobe_oe, direction_select, direction_select_oe;
  logic bus_cycle_strobe_n, bus_cycle_strobe_oe, global_data_request_n, global_data_request_oe;
  logic visibility_drive_indicator_n, visibility_clock_out, m_dir, m_we, m_rd, m_gdr, m_ind, prev = 1;
  logic [2:0] m_sel;
  int n_fail = 0, num_checks = 0, seed = 32'h1334_1d01, cyc = 0, nacc = 0, len = 0;
  emb_top dut (.*);
  emb_mem_model u_mem (.*);
  always #10 aclk = ~aclk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val(32'(got), 32'(exp));
  endtask
  always @(posedge aclk) begin
    cyc++;
    prev <= bus_cycle_strobe_n;
    if (!bus_cycle_strobe_n && prev) begin
      len <= 1;
      m_sel <= {io_space_select_n, data_space_select_n, program_space_select_n};
      {m_dir, m_we, m_rd, m_gdr, m_ind} <= {direction_select, write_strobe_n, read_strobe_n,
        global_data_request_n, visibility_drive_indicator_n};
    end else if (!bus_cycle_strobe_n) len <= len + 1;
    if (bus_cycle_strobe_n && !prev) nacc <= nacc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("Error %0t timeout", $time);
      end_sim();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_acc(input int n);
    while (nacc < n) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task automatic ext_op(input int sp, input logic g, wr, input logic [15:0] a, d, input int w);
    logic [31:0] rd;
    logic [1:0] r;
    int n;
    n = nacc + 1;
    if (wr) axi_wr(`EMB_OFS_WDATA, {16'h0000, d}, r);
    axi_wr(`EMB_OFS_CMD, {12'h000, wr, g, 2'(sp), a}, r);
    wait_acc(n);
    chk_val(32'(m_sel), 32'(3'(~(3'h1 << sp))));
    chk_bit(m_dir, !wr);
    chk_bit(m_we, !wr);
    chk_bit(m_rd, wr);
    chk_bit(m_gdr, !(g && sp == 1));
    chk_bit(m_ind, !vis);
    if (stall == 0 || w == 0) chk_val(32'(len), 32'(w + 1));
    else chk_bit(len >= 7, 1'b1);
    if (!wr) begin
      axi_rd(`EMB_OFS_STATUS, rd, r);
      chk_bit(rd[`EMB_ST_RD_VALID], 1'b1);
      axi_rd(`EMB_OFS_RDATA, rd, r);
      chk_val(32'(rd[15:0]), 32'(d));
      axi_wr(`EMB_OFS_STATUS, 32'h0000_0008, r);
    end
  endtask
  initial begin
    logic [31:0] rd;
    logic [1:0] r;
    int n, w, sp;
    logic g;
    boot_source_select <= 1'($random(seed));
    repeat (2) @(posedge aclk);
    chk_bit(space_select_oe, 1'b0);
    chk_bit(global_data_request_oe, 1'b0);
    @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`EMB_OFS_STATUS, rd, r);
    chk_bit(boot_from_external, boot_source_select);
    chk_bit(rd[`EMB_ST_BOOT_EXT], boot_source_select);
    chk_bit(ext_data_oe, 1'b1);
    axi_rd(`EMB_OFS_CTRL, rd, r);
    chk_val(rd, 32'h0000_0001);
    axi_rd(`EMB_OFS_WAIT, rd, r);
    chk_val(rd, 32'h0000_0000);
    axi_wr(8'h40, 32'h0000_0001, r);
    chk_val(32'(r), 32'(`EMB_RESP_SLVERR));
    axi_rd(8'h40, rd, r);
    chk_val({rd[29:0], r}, 32'(`EMB_RESP_SLVERR));
    ext_op(1, 1'b1, 1'b1, 16'h0003, 16'hbeef, 0);
    $display("test reset and registers done");
    emulation_float_input_n <= 1'b0;
    repeat (5) @(posedge aclk);
    chk_val(32'({space_select_oe, strobe_oe, direction_select_oe, bus_cycle_strobe_oe, global_data_request_oe}),
      32'h0000_0000);
    emulation_float_input_n <= 1'b1;
    axi_wr(`EMB_OFS_CTRL, 32'h0000_0003, r);
    repeat (5) @(posedge aclk);
    chk_val(32'({space_select_oe, strobe_oe, direction_select_oe, bus_cycle_strobe_oe, global_data_request_oe}),
      32'h0000_0008);
    axi_wr(`EMB_OFS_CTRL, 32'h0000_0000, r);
    vis = 1'b0;
    repeat (5) @(posedge aclk);
    chk_bit(ext_data_oe, 1'b0);
    $display("test float and power down done");
    for (int i = 0; i < 12; i++) begin
      w = 3 + ($unsigned($random(seed)) % 3);
      sp = i % 3;
      g = 1'($random(seed));
      stall <= ($random(seed) & 1) ? 4'h6 : 4'h0;
      axi_wr(`EMB_OFS_WAIT, 32'(w), r);
      rd = $random(seed);
      ext_op(sp, g, 1'b1, rd[31:16], rd[15:0], w);
      ext_op(sp, g, 1'b0, rd[31:16], rd[15:0], w);
    end
    stall <= 4'h6;
    axi_wr(`EMB_OFS_WAIT, 32'h0000_0000, r);
    ext_op(2, 1'b0, 1'b1, 16'h0007, 16'h1234, 0);
    $display("test random accesses done");
    axi_wr(`EMB_OFS_WAIT, 32'h0000_0007, r);
    n = nacc;
    for (int i = 0; i < 6; i++) axi_wr(`EMB_OFS_CMD, 32'h0008_0000 | i, r);
    axi_rd(`EMB_OFS_STATUS, rd, r);
    chk_bit(rd[`EMB_ST_BUSY], 1'b1);
    wait_acc(n + 6);
    chk_val(32'(nacc), 32'(n + 6));
    axi_rd(`EMB_OFS_STATUS, rd, r);
    chk_bit(rd[`EMB_ST_BUSY], 1'b0);
    $display("test fifo fill done");
    external_interface_enable <= 1'b0;
    repeat (4) @(posedge aclk);
    n = nacc;
    axi_wr(`EMB_OFS_CMD, 32'h0001_0005, r);
    repeat (20) @(posedge aclk);
    chk_val(32'(nacc), 32'(n));
    axi_rd(`EMB_OFS_STATUS, rd, r);
    chk_bit(rd[`EMB_ST_ILLEGAL], 1'b1);
    axi_wr(`EMB_OFS_STATUS, 32'h0000_0002, r);
    axi_rd(`EMB_OFS_STATUS, rd, r);
    chk_bit(rd[`EMB_ST_ILLEGAL], 1'b0);
    external_interface_enable <= 1'b1;
    $display("test disabled interface done");
    end_sim();
  end
endmodule // tb_external_memory_bus_interface
`default_nettype wire
